//--- hw/ms_timer.v
// Millisecond down-counter with its own prescaler and a one-cycle done pulse.
`timescale 1ns/1ps
`default_nettype none

module ms_timer #(
   parameter CW   = 23,
   parameter TICK = 10000
) (
   // Clock and reset.
   input  wire          clk,
   input  wire          resetn,
   input  wire          ce,
   // Control.
   input  wire          start,
   input  wire          stop,
   input  wire [CW-1:0] count,
   // Status.
   output reg           busy,
   output reg           done
);

   localparam PW = $clog2(TICK + 1);
   localparam integer  TLAST = TICK - 1;

   reg [PW-1:0] pre_r;
   reg [CW-1:0] rem_r;

   // A zero count finishes at once, so a zero delay unit never hangs the sequencer.
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         pre_r <= {PW{1'b0}};
         rem_r <= {CW{1'b0}};
         busy  <= 1'b0;
         done  <= 1'b0;
      end else if (ce) begin
         done <= 1'b0;
         if (start) begin
            pre_r <= {PW{1'b0}};
            rem_r <= count;
            busy  <= (count != {CW{1'b0}});
            done  <= (count == {CW{1'b0}});
         end else if (stop) begin
            busy <= 1'b0;
         end else if (busy) begin
            if (pre_r == TLAST[PW-1:0]) begin
               pre_r <= {PW{1'b0}};
               if (rem_r == {{(CW-1){1'b0}}, 1'b1}) begin
                  busy <= 1'b0;
                  done <= 1'b1;
               end else begin
                  rem_r <= rem_r - 1'b1;
               end
            end else begin
               pre_r <= pre_r + 1'b1;
            end
         end
      end
   end

endmodule // ms_timer

`default_nettype wire

//--- hw/pin_sync.v
// Three-stage pin synchroniser that accepts a change once the last two stages agree.
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
   parameter RST_VAL = 1'b0
) (
   // Clock and reset.
   input  wire clk,
   input  wire resetn,
   input  wire ce,
   // Pin and filtered level.
   input  wire pin,
   output reg  level
);

   reg s1_r;
   reg s2_r;
   reg s3_r;

   // The first stage feeds only the second; the level moves only on agreement.
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         s1_r  <= RST_VAL;
         s2_r  <= RST_VAL;
         s3_r  <= RST_VAL;
         level <= RST_VAL;
      end else if (ce) begin
         s1_r <= pin;
         s2_r <= s1_r;
         s3_r <= s2_r;
         if (s2_r == s3_r) begin
            level <= s3_r;
         end
      end
   end

endmodule // pin_sync

`default_nettype wire

//--- hw/ton_fault.v
// Turn-on timeout supervisor: limit and response registers, fault detection and retry sequencer.
//
// How it works
// - A 16-bit millisecond limit bounds start-up; expiry raises the turn-on fault.
// - A zero limit disables the timeout; start-up may continue forever.
// - The response is an 8-bit register written and read with byte transfers.
// - Every response encoding has defined behaviour; wrong-size or unknown accesses are refused.
// - Mode 00 keeps the output running when the fault occurs.
// - Mode 01 runs on for the delay, then applies the retry field if still faulted.
// - Mode 10 disables the output at once, then follows the retry field.
// - Mode 11 keeps the output off until the fault is cleared.
// - Retry code 000 makes no restart and stays off until cleared.
// - Retry codes 001 to 101 restart that many times, then stay off.
// - Restart attempts are spaced by two to the power of the delay field, times the delay unit.
// - Delay code n means two to the power n delay units.
// - Retry code 110 allows six restarts; 111 retries without limit.
// - The delay unit length comes from an input, not from the response byte.
`timescale 1ns/1ps
`default_nettype none
`include "ton_fault_map.vh"

module ton_fault #(
   parameter MS_CYCLES = `MS_NS / `CLK_NS,
   parameter LIMIT_W   = 16,
   parameter UNIT_W    = 16
) (
   // Clock, reset and clock enable.
   input  wire               clk,
   input  wire               resetn,
   input  wire               ce,
   // Configuration command port.
   input  wire               cmd_wr,
   input  wire               cmd_rd,
   input  wire               cmd_word,
   input  wire [7:0]         cmd_code,
   input  wire [15:0]        cmd_wdata,
   output reg  [15:0]        cmd_rdata,
   output reg                cmd_rvalid,
   output reg                cmd_err,
   // Turn-on commands and fault clearing.
   input  wire               ctrl_pin,
   input  wire               op_on,
   input  wire               clear_faults,
   input  wire               clear_status_bit,
   input  wire               other_fault,
   // Delay unit length in milliseconds.
   input  wire [UNIT_W-1:0]  fault_delay_unit,
   // Output voltage above the undervoltage fault threshold.
   input  wire               vout_above_uv,
   // Output control and status.
   output reg                output_enable,
   output reg                ton_fault_flag,
   output reg  [2:0]         attempt_count,
   output reg  [2:0]         seq_state
);

   ////////////////////////////////////////////////////////////////////////////////
   // Sequencer states.
   localparam [2:0] S_OFF   = 3'd0;
   localparam [2:0] S_RAMP  = 3'd1;
   localparam [2:0] S_RUN   = 3'd2;
   localparam [2:0] S_RIDE  = 3'd3;
   localparam [2:0] S_WAIT  = 3'd4;
   localparam [2:0] S_LATCH = 3'd5;

   localparam HW = UNIT_W + 7;

   ////////////////////////////////////////////////////////////////////////////////
   // Registers and internal signals.
   reg  [LIMIT_W-1:0] limit_r;
   reg  [7:0]         resp_r;
   reg  [2:0]         st_r;
   reg  [2:0]         st_nxt;
   reg                run_q_r;
   reg                to_start;
   reg                hd_start;
   reg                fault_evt;
   reg                att_inc;
   wire               ctrl_on;
   wire               uv_ok;
   wire               run_cmd;
   wire               clr;
   // Timer busy flags stay unconnected; the sequencer state shows when a timer runs.
   wire               to_done;
   wire               hd_done;
   wire [1:0]         mode;
   wire [2:0]         retries;
   wire [2:0]         dly_code;
   wire [HW-1:0]      hold_ms;
   wire               can_retry;

   ////////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers.
   pin_sync #(.RST_VAL(1'b0)) u_sync_ctrl (
      .clk    (clk),
      .resetn (resetn),
      .ce     (ce),
      .pin    (ctrl_pin),
      .level  (ctrl_on)
   );

   pin_sync #(.RST_VAL(1'b0)) u_sync_uv (
      .clk    (clk),
      .resetn (resetn),
      .ce     (ce),
      .pin    (vout_above_uv),
      .level  (uv_ok)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Configuration registers.
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         limit_r    <= `TON_LIMIT_RST;
         resp_r     <= `TON_RESPONSE_RST;
         cmd_rdata  <= 16'h0000;
         cmd_rvalid <= 1'b0;
         cmd_err    <= 1'b0;
      end else if (ce) begin
         cmd_rvalid <= 1'b0;
         cmd_err    <= 1'b0;
         if (cmd_wr) begin
            if (cmd_code == `CMD_TON_LIMIT && cmd_word) begin
               limit_r <= cmd_wdata;
            end else if (cmd_code == `CMD_TON_RESPONSE && !cmd_word) begin
               resp_r <= cmd_wdata[7:0];
            end else begin
               cmd_err <= 1'b1;
            end
         end else if (cmd_rd) begin
            if (cmd_code == `CMD_TON_LIMIT && cmd_word) begin
               cmd_rdata  <= limit_r;
               cmd_rvalid <= 1'b1;
            end else if (cmd_code == `CMD_TON_RESPONSE && !cmd_word) begin
               cmd_rdata  <= {8'h00, resp_r};
               cmd_rvalid <= 1'b1;
            end else begin
               cmd_err <= 1'b1;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Response fields and delay length.
   assign mode     = resp_r[`RESP_MODE_HI:`RESP_MODE_LO];
   assign retries  = resp_r[`RESP_RETRY_HI:`RESP_RETRY_LO];
   assign dly_code = resp_r[`RESP_DELAY_HI:`RESP_DELAY_LO];

   // Two to the power of the code, in units whose length arrives from outside.
   assign hold_ms = {7'h00, fault_delay_unit} << dly_code;

   // Code 111 never runs out; 001 to 110 allow that many restarts; 000 allows none.
   assign can_retry = (retries == `RETRY_FOREVER) ||
                      (attempt_count < retries);

   // Run is the control pin and the operation command together.
   assign run_cmd = ctrl_on & op_on;

   // An off command, a status-bit clear or a clear-all wipes the fault.
   assign clr = clear_faults | clear_status_bit | (run_q_r & ~run_cmd);

   ////////////////////////////////////////////////////////////////////////////////
   // Timers: start-up timeout and delay/holdoff.
   ms_timer #(.CW(LIMIT_W), .TICK(MS_CYCLES)) u_timeout (
      .clk    (clk),
      .resetn (resetn),
      .ce     (ce),
      .start  (to_start),
      .stop   (st_r != S_RAMP),
      .count  (limit_r),
      .busy   (),
      .done   (to_done)
   );

   ms_timer #(.CW(HW), .TICK(MS_CYCLES)) u_holdoff (
      .clk    (clk),
      .resetn (resetn),
      .ce     (ce),
      .start  (hd_start),
      .stop   (st_r != S_RIDE && st_r != S_WAIT),
      .count  (hold_ms),
      .busy   (),
      .done   (hd_done)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Sequencer next state.
   always @* begin
      st_nxt    = st_r;
      to_start  = 1'b0;
      hd_start  = 1'b0;
      fault_evt = 1'b0;
      att_inc   = 1'b0;
      case (st_r)
         S_OFF: begin
            if (run_cmd && !clr) begin
               st_nxt   = S_RAMP;
               to_start = (limit_r != {LIMIT_W{1'b0}});
            end
         end
         S_RAMP: begin
            if (uv_ok) begin
               st_nxt = S_RUN;
            end else if (to_done) begin
               fault_evt = 1'b1;
               case (mode)
                  `MODE_IGNORE: st_nxt = S_RUN;
                  `MODE_RIDE: begin
                     st_nxt   = S_RIDE;
                     hd_start = 1'b1;
                  end
                  `MODE_DISABLE: begin
                     if (can_retry) begin
                        st_nxt   = S_WAIT;
                        hd_start = 1'b1;
                     end else begin
                        st_nxt = S_LATCH;
                     end
                  end
                  default: st_nxt = S_LATCH;
               endcase
            end
         end
         S_RIDE: begin
            if (hd_done) begin
               if (uv_ok) begin
                  st_nxt = S_RUN;
               end else if (can_retry) begin
                  st_nxt   = S_WAIT;
                  hd_start = 1'b1;
               end else begin
                  st_nxt = S_LATCH;
               end
            end
         end
         S_WAIT: begin
            if (hd_done) begin
               st_nxt   = S_RAMP;
               att_inc  = 1'b1;
               to_start = (limit_r != {LIMIT_W{1'b0}});
            end
         end
         S_LATCH: begin
            if (clr) begin
               st_nxt = S_OFF;
            end
         end
         S_RUN: begin
            st_nxt = S_RUN;
         end
         default: st_nxt = S_OFF;
      endcase
      // Shutdown by another fault ends any retrying and holds the output off.
      if (other_fault && st_nxt != S_OFF) begin
         st_nxt   = S_LATCH;
         to_start = 1'b0;
         hd_start = 1'b0;
         att_inc  = 1'b0;
      end
      // Dropping the run command always wins and ends unlimited retrying.
      if (!run_cmd) begin
         st_nxt   = S_OFF;
         to_start = 1'b0;
         hd_start = 1'b0;
         att_inc  = 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Sequencer state, fault flag, attempt counter and output enable.
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         st_r           <= S_OFF;
         run_q_r        <= 1'b0;
         ton_fault_flag <= 1'b0;
         attempt_count  <= 3'd0;
         output_enable  <= 1'b0;
         seq_state      <= S_OFF;
      end else if (ce) begin
         st_r      <= st_nxt;
         seq_state <= st_nxt;
         run_q_r   <= run_cmd;
         // A new fault in the cycle of a clear keeps the flag set.
         ton_fault_flag <= fault_evt | (ton_fault_flag & ~clr);
         if (clr) begin
            attempt_count <= 3'd0;
         end else if (att_inc && attempt_count != 3'd7) begin
            attempt_count <= attempt_count + 3'd1;
         end
         // The output stays up while riding through and under the ignore mode.
         output_enable <= (st_nxt == S_RAMP) || (st_nxt == S_RUN) ||
                          (st_nxt == S_RIDE);
      end
   end

endmodule // ton_fault

`default_nettype wire

//--- inc/ton_fault_map.vh
// Command codes, field positions, reset values and timing figures of the turn-on fault block.
`ifndef TON_FAULT_MAP_VH
`define TON_FAULT_MAP_VH

// Command codes of the two configuration registers.
`define CMD_TON_LIMIT      8'h62
`define CMD_TON_RESPONSE   8'h63

// Fields of the response byte.
`define RESP_MODE_HI       7
`define RESP_MODE_LO       6
`define RESP_RETRY_HI      5
`define RESP_RETRY_LO      3
`define RESP_DELAY_HI      2
`define RESP_DELAY_LO      0

// Response modes.
`define MODE_IGNORE        2'b00
`define MODE_RIDE          2'b01
`define MODE_DISABLE       2'b10
`define MODE_LATCH         2'b11

// Retry codes with a special meaning.
`define RETRY_NONE         3'b000
`define RETRY_FOREVER      3'b111

// Reset values.
`define TON_LIMIT_RST      16'h0000
`define TON_RESPONSE_RST   8'h80

// Timing: one millisecond in ns and the clock period in ns.
`define MS_NS              1000000
`define CLK_NS             100

`endif

//--- test/ton_fault_chk.sv
// Port assertions for the turn-on timeout supervisor.
`timescale 1ns/1ps
`default_nettype none
module ton_fault_chk (
   // Clock and reset.
   input wire logic        clk,
   input wire logic        resetn,
   input wire logic        ce,
   // Command port.
   input wire logic        cmd_wr,
   input wire logic        cmd_rd,
   input wire logic        cmd_word,
   input wire logic [7:0]  cmd_code,
   input wire logic [15:0] cmd_wdata,
   input wire logic [15:0] cmd_rdata,
   input wire logic        cmd_rvalid,
   input wire logic        cmd_err,
   // Supervisor.
   input wire logic        other_fault,
   input wire logic        output_enable,
   input wire logic        ton_fault_flag,
   input wire logic [2:0]  attempt_count,
   input wire logic [2:0]  seq_state
);
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   logic [7:0]  resp_r;
   logic [15:0] lim_r;
   wire acc = ce && (cmd_wr || cmd_rd);
   wire bad = acc && ((cmd_code == 8'h63) ? cmd_word : ((cmd_code == 8'h62) ? !cmd_word : 1'b1));
   wire rsp_wr = ce && cmd_wr && cmd_code == 8'h63 && !cmd_word;
   wire rsp_rd = ce && cmd_rd && !cmd_wr && cmd_code == 8'h63 && !cmd_word;
   wire lim_rd = ce && cmd_rd && !cmd_wr && cmd_code == 8'h62 && cmd_word;
   // Shadows let the checker know the programmed setup without looking inside.
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         resp_r <= 8'h80;
         lim_r  <= 16'h0000;
      end else begin
         if (rsp_wr) resp_r <= cmd_wdata[7:0];
         if (ce && cmd_wr && cmd_code == 8'h62 && cmd_word) lim_r <= cmd_wdata;
      end
   end
   ////////////////////////////////////////////////////////////
   sequence s_wr_rd;
      rsp_wr ##1 rsp_rd;
   endsequence
   sequence s_fault;
      $rose(ton_fault_flag);
   endsequence
   AST_RESP_READ: assert property (rsp_rd |=> cmd_rvalid &&
      cmd_rdata == {8'h00, $past(resp_r)})
      else $error("byte read of response wrong");
   AST_WR_RD: assert property (s_wr_rd |=> cmd_rdata[7:0] == $past(cmd_wdata[7:0], 2))
      else $error("response readback differs from write");
   AST_LIMIT_READ: assert property (lim_rd |=> cmd_rvalid && cmd_rdata == $past(lim_r))
      else $error("limit readback wrong");
   AST_REFUSE: assert property (bad |=> cmd_err && !cmd_rvalid)
      else $error("bad access not refused");
   AST_NO_LIMIT: assert property (lim_r == 16'h0000 |-> !$rose(ton_fault_flag))
      else $error("fault raised with zero limit");
   AST_IGNORE: assert property (s_fault ##0 resp_r[7:6] == 2'b00 |-> output_enable)
      else $error("ignore mode dropped output");
   AST_RIDE_ON: assert property (seq_state == 3'd3 |-> output_enable)
      else $error("output off while riding");
   AST_DISABLE: assert property (s_fault ##0 resp_r[7:6] == 2'b10 |->
      ##[0:1] !output_enable)
      else $error("disable mode kept output on");
   AST_LATCH_NOW: assert property (s_fault ##0 resp_r[7:6] == 2'b11 |->
      ##[0:1] seq_state == 3'd5)
      else $error("latch mode did not latch");
   AST_LATCH_OFF: assert property (seq_state == 3'd5 |-> !output_enable)
      else $error("output on while latched");
   AST_RETRY_COUNT: assert property ($rose(seq_state == 3'd5) && resp_r[7:6] == 2'b10
      && !$past(other_fault) |-> attempt_count == resp_r[5:3])
      else $error("latched with wrong attempt count");
endmodule // ton_fault_chk
bind ton_fault ton_fault_chk ton_fault_chk_i (
   .clk(clk), .resetn(resetn), .ce(ce), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd),
   .cmd_word(cmd_word), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .cmd_rdata(cmd_rdata),
   .cmd_rvalid(cmd_rvalid), .cmd_err(cmd_err), .other_fault(other_fault),
   .output_enable(output_enable), .ton_fault_flag(ton_fault_flag),
   .attempt_count(attempt_count), .seq_state(seq_state));
`default_nettype wire

//--- test/ton_host.sv
// Host model issuing configuration commands to the supervisor.
`timescale 1ns/1ps
`default_nettype none
module ton_host (
   // Clock.
   input  wire logic        clk,
   // Request.
   output var  logic        cmd_wr,
   output var  logic        cmd_rd,
   output var  logic        cmd_word,
   output var  logic [7:0]  cmd_code,
   output var  logic [15:0] cmd_wdata,
   // Answer.
   input  wire logic [15:0] cmd_rdata,
   input  wire logic        cmd_rvalid,
   input  wire logic        cmd_err
);
   initial begin
      {cmd_wr, cmd_rd, cmd_word} = 3'b000;
      cmd_code = 8'h00;
      cmd_wdata = 16'h0000;
   end
   // Each call presents one request for exactly one taking edge.
   task put(input w, input wd, input [7:0] c, input [15:0] d);
      begin
         @(posedge clk);
         cmd_wr <= w;
         cmd_rd <= !w;
         cmd_word <= wd;
         cmd_code <= c;
         cmd_wdata <= d;
      end
   endtask
   // Idle lines are inverted so a stale value cannot pass as valid data.
   task fin(output [15:0] q, output e, output v);
      begin
         @(posedge clk);
         {cmd_wr, cmd_rd} <= 2'b00;
         cmd_code <= ~cmd_code;
         cmd_wdata <= ~cmd_wdata;
         @(negedge clk);
         q = cmd_rdata;
         e = cmd_err;
         v = cmd_rvalid;
      end
   endtask
endmodule // ton_host
`default_nettype wire

//--- test/turn_on_timeout_fault_response_test.sv
// Self-checking bench for the turn-on timeout supervisor.
`timescale 1ns/1ps
`default_nettype none
module turn_on_timeout_fault_response_test;
   localparam MS = 10;
   logic clk, resetn, ce, ctrl_pin, op_on, clear_faults, clear_status_bit;
   logic other_fault, vout_above_uv, rise_en, e, v;
   logic [15:0] unit, q;
   logic [31:0] r;
   wire cmd_wr, cmd_rd, cmd_word, cmd_rvalid, cmd_err, output_enable, ton_fault_flag;
   wire [7:0] cmd_code;
   wire [15:0] cmd_wdata, cmd_rdata;
   wire [2:0] attempt_count, seq_state;
   integer n_fail, checked, seed, hold_cyc, i, n, d;
   ton_fault #(.MS_CYCLES(MS)) ton_fault_i (.clk(clk), .resetn(resetn), .ce(ce),
      .cmd_wr(cmd_wr), .cmd_rd(cmd_rd), .cmd_word(cmd_word), .cmd_code(cmd_code),
      .cmd_wdata(cmd_wdata), .cmd_rdata(cmd_rdata), .cmd_rvalid(cmd_rvalid), .cmd_err(cmd_err),
      .ctrl_pin(ctrl_pin), .op_on(op_on), .clear_faults(clear_faults),
      .clear_status_bit(clear_status_bit), .other_fault(other_fault),
      .fault_delay_unit(unit), .vout_above_uv(vout_above_uv), .output_enable(output_enable),
      .ton_fault_flag(ton_fault_flag), .attempt_count(attempt_count), .seq_state(seq_state));
   ton_host ton_host_i (.clk(clk), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd), .cmd_word(cmd_word),
      .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .cmd_rdata(cmd_rdata),
      .cmd_rvalid(cmd_rvalid), .cmd_err(cmd_err));
   always #50 clk = ~clk;
   always @(posedge clk) begin
      if (seq_state === 3'd4) hold_cyc <= hold_cyc + 1;
      if (rise_en && seq_state === 3'd3) vout_above_uv <= 1'b1;
   end
   ////////////////////////////////////////////////////////////
   task conclude;
      begin
         $display("checked %0d n_fail %0d", checked, n_fail);
         if (n_fail == 0 && checked > 0) $display("ALL TESTS PASSED");
         else $display("TESTS FAILED");
         $finish;
      end
   endtask
   task cmp(input [15:0] g, input [15:0] x);
      begin
         checked = checked + 1;
         if (g !== x) begin
            n_fail = n_fail + 1;
            $display("[ERR] %0t got %h expected %h", $time, g, x);
         end
      end
   endtask
   task near(input integer g, input integer x, input integer t);
      begin
         checked = checked + 1;
         if (g < x - t || g > x + t) begin
            n_fail = n_fail + 1;
            $display("[ERR] %0t hold %0d cycles expected %0d", $time, g, x);
         end
      end
   endtask
   task acc(input w, input wd, input [7:0] c, input [15:0] dt, input [15:0] x, input xe);
      begin
         ton_host_i.put(w, wd, c, dt);
         ton_host_i.fin(q, e, v);
         cmp({14'h0000, v, e}, {14'h0000, !w && !xe, xe});
         if (!w && !xe) cmp(q, x);
      end
   endtask
   task wait_st(input [2:0] s);
      integer k;
      begin
         k = 0;
         while (seq_state !== s && k < 4000) begin
            @(posedge clk);
            k = k + 1;
         end
         if (seq_state !== s) begin
            n_fail = n_fail + 1;
            $display("[ERR] %0t state %0d never reached", $time, s);
         end
      end
   endtask
   // Dropping the run command and clearing first gives every case a clean start.
   task start(input [7:0] rsp, input [15:0] u);
      begin
         @(posedge clk);
         {ctrl_pin, op_on} <= 2'b00;
         clear_faults <= 1'b1;
         vout_above_uv <= 1'b0;
         acc(1'b1, 1'b0, 8'h63, {8'h00, rsp}, 16'h0000, 1'b0);
         // The clear holds until the synchronised pin is low, so no stray start slips in.
         repeat (6) @(posedge clk);
         clear_faults <= 1'b0;
         unit <= u;
         hold_cyc = 0;
         {ctrl_pin, op_on} <= 2'b11;
      end
   endtask
   function [6:0] model(input [7:0] rsp, input rise);
      begin
         if (rsp[7:6] == 2'b00 || (rsp[7:6] == 2'b01 && rise)) model = {1'b1, 3'd0, 3'd2};
         else if (rsp[7:6] == 2'b11) model = {1'b0, 3'd0, 3'd5};
         else model = {1'b0, rsp[5:3], 3'd5};
      end
   endfunction
   task run(input [7:0] rsp, input rise, input [15:0] u);
      reg [6:0] x;
      begin
         x = model(rsp, rise);
         rise_en = rise;
         start(rsp, u);
         wait_st(x[2:0]);
         rise_en = 1'b0;
         cmp({8'h00, output_enable, ton_fault_flag, attempt_count, seq_state},
             {8'h00, x[6], 1'b1, x[5:3], x[2:0]});
         if (x[2:0] == 3'd5) begin
            near(hold_cyc, x[5:3] * (unit << rsp[2:0]) * MS, 2 * x[5:3] + 2);
            clear_status_bit <= 1'b1;
            @(posedge clk);
            clear_status_bit <= 1'b0;
            wait_st(3'd1);
            cmp({14'h0000, ton_fault_flag, attempt_count != 3'd0}, 16'h0000);
         end
      end
   endtask
   ////////////////////////////////////////////////////////////
   initial begin
      seed = 36837;
      {n_fail, checked, hold_cyc} = 0;
      {clk, resetn, ctrl_pin, op_on, clear_faults, clear_status_bit} = 6'h00;
      {other_fault, vout_above_uv, rise_en} = 3'b000;
      ce = 1'b1;
      unit = 16'h0001;
      repeat (12) @(posedge clk);
      resetn <= 1'b1;
      acc(1'b0, 1'b0, 8'h63, 16'h0000, 16'h0080, 1'b0);
      acc(1'b0, 1'b1, 8'h62, 16'h0000, 16'h0000, 1'b0);
      acc(1'b0, 1'b1, 8'h63, 16'h0000, 16'h0000, 1'b1);
      acc(1'b1, 1'b0, 8'h62, 16'h0001, 16'h0000, 1'b1);
      acc(1'b0, 1'b0, 8'h64, 16'h0000, 16'h0000, 1'b1);
      for (i = 0; i < 4; i = i + 1) begin
         r = $random(seed);
         acc(1'b1, 1'b1, 8'h62, r[15:0], 16'h0000, 1'b0);
         acc(1'b0, 1'b1, 8'h62, 16'h0000, r[15:0], 1'b0);
         ton_host_i.put(1'b1, 1'b0, 8'h63, r[15:0]);
         ton_host_i.put(1'b0, 1'b0, 8'h63, 16'h0000);
         ton_host_i.fin(q, e, v);
         cmp(q, {8'h00, r[7:0]});
      end
      acc(1'b1, 1'b1, 8'h62, 16'h0000, 16'h0000, 1'b0);
      start(8'h00, 16'h0001);
      repeat (300) @(posedge clk);
      cmp({12'h000, ton_fault_flag, seq_state}, 16'h0001);
      other_fault <= 1'b1;
      wait_st(3'd5);
      cmp({14'h0000, ton_fault_flag, output_enable}, 16'h0000);
      other_fault <= 1'b0;
      acc(1'b1, 1'b1, 8'h62, 16'h0001, 16'h0000, 1'b0);
      run(8'h00, 1'b0, 16'h0001);
      run(8'hc0, 1'b0, 16'h0001);
      run(8'h80, 1'b0, 16'h0001);
      run(8'hb0, 1'b0, 16'h0001);
      run(8'h42, 1'b1, 16'h0001);
      run(8'h41, 1'b0, 16'h0002);
      for (i = 0; i < 4; i = i + 1) begin
         r = $random(seed);
         n = 1 + r[7:0] % 5;
         d = r[9:8] % 3;
         run({2'b10, n[2:0], d[2:0]}, 1'b0, 16'h0001 + r[10]);
      end
      start(8'hb8, 16'h0001);
      repeat (500) @(posedge clk);
      cmp({14'h0000, seq_state === 3'd5, ton_fault_flag}, 16'h0001);
      // A low clock enable must freeze the sequencer, its timers and the retry count.
      ce <= 1'b0;
      @(posedge clk);
      q = {8'h00, output_enable, ton_fault_flag, attempt_count, seq_state};
      repeat (50) @(posedge clk);
      cmp({8'h00, output_enable, ton_fault_flag, attempt_count, seq_state}, q);
      ce <= 1'b1;
      conclude;
   end
   initial begin
      #(40000 * 100);
      n_fail = n_fail + 1;
      conclude;
   end
endmodule // turn_on_timeout_fault_response_test
`default_nettype wire
